//--- inc/rail_seq_regs.svh
`ifndef RAIL_SEQ_REGS_SVH
`define RAIL_SEQ_REGS_SVH

// Register byte offsets on the APB slave
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_STRAP       8'h08
`define OFS_ICCMAX      8'h0c
`define OFS_TEMP        8'h10
`define OFS_FREQ        8'h14
`define OFS_DAC         8'h18

// Control register fields
`define CTRL_EN_BIT     0
`define CTRL_SLEW_LO    8
`define CTRL_SLEW_HI    15
`define CTRL_TARGET_LO  16
`define CTRL_TARGET_HI  23

// Reset values and limits
`define SLEW_RESET      8'h04
`define TARGET_RESET    8'h00
`define DAC_ZERO        8'h00
`define SYSTEM_POWER_MONITOR_IN_ADDR       4'hd
`define RAIL_A_ADDR     4'h2
`define RAIL_B_ADDR     4'h3
`define RAMP_SUPPLY_LOCKOUT_CODE  8'h66
`define ICCMAX_FULL     8'h80
`define ADC_CHANNELS    2
`define FREQ_MIN_CODE   8'h14
`define FREQ_MAX_CODE   8'h78
`define UNMAPPED_DATA   32'h0000_0000

`endif

//--- inc/rail_seq_pkg.sv
package rail_seq_pkg;

    // Sequencer states, Gray-coded along the startup path
    typedef enum logic [2:0] {
        ST_LOCKOUT = 3'b000,
        ST_CAPTURE = 3'b001,
        ST_MIDLVL  = 3'b011,
        ST_RAMP    = 3'b010,
        ST_RUN     = 3'b110
    } seq_state_t;

    // Three-level PWM drive: mid-level means the output is released
    typedef enum logic [1:0] {
        PWM_MID  = 2'b00,
        PWM_LOW  = 2'b01,
        PWM_HIGH = 2'b10
    } pwm_level_t;

    // Strap configuration captured after the supply clears lockout
    typedef struct packed {
        logic [1:0] arrangement;   // Group of four in the address strap
        logic [1:0] boot_sel;      // 0 V, 1.2 V, 1.05 V, 1.0 V
        logic       dual_single;   // Two-phase rail runs single-phase
        logic       rail_a_off;    // Single-phase rail a disabled
        logic       rail_b_off;    // Single-phase rail b disabled
        logic       monitor_off;   // System power monitor disabled
        logic [7:0] freq_shared;
        logic [7:0] freq_aux;
    } strap_cfg_t;

    // Analog front-end samples presented as digital codes
    typedef struct packed {
        logic [7:0] ramp_supply;
        logic [7:0] iccmax_pin;
        logic [7:0] temp_dual;
        logic [7:0] temp_single;
    } adc_codes_t;

endpackage : rail_seq_pkg

//--- logic/sync2.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a bus of levels from the pins
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : sync2

//--- logic/soft_start_ramp.sv
`timescale 1ns/1ps
`include "rail_seq_regs.svh"
// Digital soft-start counter: one step per slew interval up to target
module soft_start_ramp (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       run,
    input  wire logic [7:0] slew_div,
    input  wire logic [7:0] target,
    output logic      [7:0] dac_code,
    output logic            at_target
);
    logic [7:0] tick_q;
    logic [7:0] tick_d;
    logic [7:0] dac_d;
    wire        step = run && (tick_q >= slew_div) && (dac_code < target);

    // Counter restarts from zero whenever the ramp is not running
    assign tick_d    = (!run || tick_q >= slew_div) ? `DAC_ZERO
                                                    : tick_q + 8'h01;
    assign dac_d     = !run ? `DAC_ZERO
                     : step ? dac_code + 8'h01 : dac_code;
    assign at_target = run && (dac_code == target);

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tick_q   <= `DAC_ZERO;
            dac_code <= `DAC_ZERO;
        end
        else
        begin
            tick_q   <= tick_d;
            dac_code <= dac_d;
        end
    end

    // Counter must sit at zero once the ramp has been off a cycle
    // (R3) parked at zero
    sequence s_stopped;
        !run ##1 !run;
    endsequence
    property p_dac_zero_idle;
        @(posedge clk_sys) disable iff (!reset_n)
        s_stopped |-> dac_code == `DAC_ZERO;
    endproperty
    a_dac_zero_idle: assert property (p_dac_zero_idle) // (R3)
        else $error("dac not zero before ramp");
endmodule : soft_start_ramp

//--- logic/rail_startup_config_sequencer.sv
`timescale 1ns/1ps
`include "rail_seq_regs.svh"
// Operation
// (R1) Above supply lockout, capture straps and park all PWM outputs mid-level.
// (R2) On enable, drive gate driver enable high.
// (R3) Soft start counter steps DAC from zero to target at slew rate.
// (R4) Each PWM stays mid-level until its rail's first pulse, then high.
// (R5) Disable returns every PWM output to mid-level.
// (R6) Second sense strapped high: dual rail runs single-phase, second PWM ignored.
// (R7) Single-phase sense strapped high: rail off, ignores its bus addresses.
// (R8) Monitor tied to supply: monitor off, no answer at address 0Dh.
// (R9) Address strap: four groups of arrangement, boot 0/1.2/1.05/1.0 V.
// (R10) Ramp supply lockout at 4 V, checked only while enabled.
// (R11) At enable load dual-rail max current, 2 V full scale is 128 A.
// (R12) Frequency 200 kHz to 1.2 MHz; shared and auxiliary settings.
// (R13) Shared oscillator clocks ramp in two-phase, else only stabilises.
// (R14) Dual-edge ramp only with two phases; three modulator ramps separately.
// (R15) Sample both temperature inputs through the converter.
// (R16) Straps stay fixed until supply falls below lockout and returns.
module rail_startup_config_sequencer (
    input  wire logic                      clk_sys,
    input  wire logic                      reset_n,
    input  wire logic                      supply_ok,
    input  wire logic                      enable_in,
    input  wire logic [3:0]                addr_strap,
    input  wire logic                      dual_rail_second_sense_in,
    input  wire logic                      sense_a_at_supply,
    input  wire logic                      sense_b_at_supply,
    input  wire logic                      system_power_monitor_in,
    input  wire logic [7:0]                freq_strap_shared,
    input  wire logic [7:0]                freq_strap_aux,
    input  wire rail_seq_pkg::adc_codes_t  adc_in,
    input  wire logic [2:0]                first_pulse,
    input  wire logic [3:0]                bus_addr,
    input  wire logic                      bus_addr_valid,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    output logic                           gate_driver_enable,
    output rail_seq_pkg::pwm_level_t       pwm_out [4],
    output logic                           bus_addr_ack,
    output logic      [7:0]                dac_code,
    output logic                           dual_edge_ramp_en,
    output logic                           shared_osc_master,
    output logic      [2:0]                modulator_ramp_en,
    output logic      [7:0]                freq_shared,
    output logic      [7:0]                freq_aux
);
    import rail_seq_pkg::*;

    // Checks at the bottom sample on this clock and sleep in reset
    default clocking dflt_cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    seq_state_t  state_q, state_d;
    strap_cfg_t  cfg_q;
    logic [31:0] ctrl_q;
    logic [7:0]  iccmax_q;
    logic [7:0]  temp_q [`ADC_CHANNELS];
    logic [2:0]  pulsed_q;
    logic [3:0]  addr_s, pins_s;
    logic [7:0]  fs_s, fa_s;
    logic        supply_s, enable_s, sw_en;
    logic        at_target;

    // Pin levels cross into the clock domain first
    sync2 #(.W(26)) u_sync (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .async_in ({supply_ok, enable_in, dual_rail_second_sense_in,
                    sense_a_at_supply, sense_b_at_supply,
                    system_power_monitor_in, addr_strap,
                    freq_strap_shared, freq_strap_aux}),
        .sync_out ({supply_s, enable_s, pins_s, addr_s, fs_s, fa_s})
    );

    // Ramp supply lockout only matters while the controller is enabled
    // (R10) enabled-only lockout
    wire ramp_ok  = adc_in.ramp_supply >= `RAMP_SUPPLY_LOCKOUT_CODE;
    wire enabled  = enable_s && sw_en;
    wire run_ok   = enabled && ramp_ok;

    // Sequencer next state
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_LOCKOUT: if (supply_s) state_d = ST_CAPTURE;
            ST_CAPTURE: state_d = ST_MIDLVL;
            ST_MIDLVL:  if (run_ok) state_d = ST_RAMP;
            ST_RAMP:    if (!run_ok) state_d = ST_MIDLVL;
                        else if (at_target) state_d = ST_RUN;
            ST_RUN:     if (!run_ok) state_d = ST_MIDLVL;
            default:    state_d = ST_LOCKOUT;
        endcase
        if (!supply_s)
            state_d = ST_LOCKOUT;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            state_q <= ST_LOCKOUT;
        else
            state_q <= state_d;
    end

    // Straps are captured once per rise of the supply
    // (R1) capture after lockout
    // (R16) hold until next rise
    // (R9) address strap decode
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            cfg_q <= '0;
        else if (state_q == ST_CAPTURE)
        begin
            cfg_q.arrangement <= addr_s[3:2];
            cfg_q.boot_sel    <= addr_s[1:0];
            // (R6) single-phase strap
            cfg_q.dual_single <= pins_s[3];
            // (R7) rail disable straps
            cfg_q.rail_a_off  <= pins_s[2];
            cfg_q.rail_b_off  <= pins_s[1];
            // (R8) monitor disable strap
            cfg_q.monitor_off <= pins_s[0];
            cfg_q.freq_shared <= clamp_freq(fs_s);
            cfg_q.freq_aux    <= clamp_freq(fa_s);
        end
    end

    // (R12) frequency range clamp
    function automatic logic [7:0] clamp_freq(input logic [7:0] c);
        if (c < `FREQ_MIN_CODE)
            clamp_freq = `FREQ_MIN_CODE;
        else if (c > `FREQ_MAX_CODE)
            clamp_freq = `FREQ_MAX_CODE;
        else
            clamp_freq = c;
    endfunction : clamp_freq
    assign freq_shared = cfg_q.freq_shared;
    assign freq_aux    = cfg_q.freq_aux;
    // (R3) soft start counter
    soft_start_ramp u_ramp (
        .clk_sys   (clk_sys),
        .reset_n   (reset_n),
        .run       (state_q == ST_RAMP || state_q == ST_RUN),
        .slew_div  (ctrl_q[`CTRL_SLEW_HI:`CTRL_SLEW_LO]),
        .target    (ctrl_q[`CTRL_TARGET_HI:`CTRL_TARGET_LO]),
        .dac_code  (dac_code),
        .at_target (at_target)
    );

    // (R2) gate driver enable
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            gate_driver_enable <= 1'b0;
        else
            gate_driver_enable <= state_d == ST_RAMP || state_d == ST_RUN;
    end

    // First pulse latches per rail; cleared whenever ramp stops
    // (R4) mid-level until first pulse
    wire ramping = state_q == ST_RAMP || state_q == ST_RUN;
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            pulsed_q <= '0;
        else if (!ramping)
            pulsed_q <= '0;
        else
            pulsed_q <= pulsed_q | first_pulse;
    end

    // Index 0/1 dual rail phases, 2 rail a, 3 rail b
    // (R5) mid-level when disabled
    // (R6) second phase ignored
    generate
        for (genvar i = 0; i < 4; i++)
        begin : g_pwm
            localparam int SRC = (i < 2) ? 0 : i - 1;
            wire off = (i == 1 && cfg_q.dual_single) ||
                       (i == 2 && cfg_q.rail_a_off) ||
                       (i == 3 && cfg_q.rail_b_off);
            always_ff @(posedge clk_sys or negedge reset_n)
            begin
                if (!reset_n)
                    pwm_out[i] <= PWM_MID;
                else if (ramping && !off && pulsed_q[SRC])
                    pwm_out[i] <= PWM_HIGH;
                else
                    pwm_out[i] <= PWM_MID;
            end
        end
    endgenerate
    // (R13) shared oscillator role
    // (R14) ramp generator enables
    assign shared_osc_master = state_q != ST_LOCKOUT && !cfg_q.dual_single;
    assign dual_edge_ramp_en = ramping && !cfg_q.dual_single;
    assign modulator_ramp_en = {3{ramping}} &
        {!cfg_q.rail_b_off, !cfg_q.rail_a_off, cfg_q.dual_single};

    // Address calls answered only for live functions
    // (R7) disabled rails silent
    // (R8) no answer at 0Dh
    function automatic logic addr_live(input logic [3:0] a,
                                       input strap_cfg_t c);
        if (a == `SYSTEM_POWER_MONITOR_IN_ADDR)
            addr_live = !c.monitor_off;
        else if (a == `RAIL_A_ADDR)
            addr_live = !c.rail_a_off;
        else if (a == `RAIL_B_ADDR)
            addr_live = !c.rail_b_off;
        else
            addr_live = 1'b1;
    endfunction : addr_live
    assign bus_addr_ack = bus_addr_valid && state_q != ST_LOCKOUT &&
                          addr_live(bus_addr, cfg_q);

    // Max current loaded on the enable edge, temperatures each cycle
    // (R11) load at enable
    // (R15) sample temperatures
    wire en_edge = state_q == ST_MIDLVL && state_d == ST_RAMP;
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            iccmax_q  <= '0;
            temp_q    <= '{default: '0};
        end
        else
        begin
            if (en_edge)
                iccmax_q <= scale_icc(adc_in.iccmax_pin);
            temp_q[0] <= adc_in.temp_dual;
            temp_q[1] <= adc_in.temp_single;
        end
    end

    // Code 0xff is 2 V full scale, mapped onto 0..127 A
    function automatic logic [7:0] scale_icc(input logic [7:0] v);
        logic [15:0] p;
        p         = {8'h00, v} * {8'h00, `ICCMAX_FULL};
        scale_icc = p[15:8];
    endfunction : scale_icc

    // APB slave, zero wait state; unmapped reads zero with error
    wire wr = psel && penable && pwrite;
    wire hit_ctrl = paddr == `OFS_CTRL;
    wire mapped = hit_ctrl || paddr == `OFS_STATUS ||
                  paddr == `OFS_STRAP || paddr == `OFS_ICCMAX ||
                  paddr == `OFS_TEMP || paddr == `OFS_FREQ ||
                  paddr == `OFS_DAC;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign sw_en   = ctrl_q[`CTRL_EN_BIT];

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            ctrl_q <= {8'h00, `TARGET_RESET, `SLEW_RESET, 8'h00};
        else if (wr && hit_ctrl)
            ctrl_q <= pwdata;
    end

    // Read data registered in setup phase for the access edge
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            prdata <= `UNMAPPED_DATA;
        else if (psel && !penable)
        begin
            if (paddr == `OFS_CTRL)
                prdata <= ctrl_q;
            else if (paddr == `OFS_STATUS)
                prdata <= {24'h0, gate_driver_enable, pulsed_q,
                           ramp_ok, state_q};
            else if (paddr == `OFS_STRAP)
                prdata <= {24'h0, cfg_q.arrangement, cfg_q.boot_sel,
                           cfg_q.dual_single, cfg_q.rail_a_off,
                           cfg_q.rail_b_off, cfg_q.monitor_off};
            else if (paddr == `OFS_ICCMAX)
                prdata <= {24'h0, iccmax_q};
            else if (paddr == `OFS_TEMP)
                prdata <= {16'h0, temp_q[1], temp_q[0]};
            else if (paddr == `OFS_FREQ)
                prdata <= {16'h0, cfg_q.freq_aux, cfg_q.freq_shared};
            else if (paddr == `OFS_DAC)
                prdata <= {24'h0, dac_code};
            else
                prdata <= `UNMAPPED_DATA;
        end
    end

    // Checks
    property p_gate_follows_state;
        gate_driver_enable == (state_q inside {ST_RAMP, ST_RUN});
    endproperty
    a_gate_follows_state: assert property (p_gate_follows_state) // (R2)
        else $error("gate enable without ramp");
    property p_mid_when_off;
        !ramping |=> pwm_out[0] == PWM_MID && pwm_out[2] == PWM_MID;
    endproperty
    a_mid_when_off: assert property (p_mid_when_off) // (R5)
        else $error("pwm not mid when disabled");
    property p_second_ignored;
        cfg_q.dual_single |-> pwm_out[1] == PWM_MID;
    endproperty
    a_second_ignored: assert property (p_second_ignored) // (R6)
        else $error("second phase driven in single mode");
    property p_system_power_monitor_in_silent;
        cfg_q.monitor_off && bus_addr == `SYSTEM_POWER_MONITOR_IN_ADDR |-> !bus_addr_ack;
    endproperty
    a_system_power_monitor_in_silent: assert property (p_system_power_monitor_in_silent) // (R8)
        else $error("monitor address answered");
    property p_rail_silent;
        cfg_q.rail_a_off && bus_addr == `RAIL_A_ADDR |-> !bus_addr_ack;
    endproperty
    a_rail_silent: assert property (p_rail_silent) // (R7)
        else $error("disabled rail answered");
    property p_cfg_stable;
        state_q != ST_CAPTURE |=> $stable(cfg_q);
    endproperty
    a_cfg_stable: assert property (p_cfg_stable) // (R16)
        else $error("strap config changed");
    property p_ramp_supply_lockout;
        state_q == ST_RUN && !ramp_ok |=> state_q != ST_RUN;
    endproperty
    a_ramp_supply_lockout: assert property (p_ramp_supply_lockout) // (R10)
        else $error("ran below ramp lockout");
endmodule : rail_startup_config_sequencer

//--- dv/power_stage_model.sv
`timescale 1ns/1ps
// Gate drivers and power stages: each rail reports its first pulse
// some cycles after the drivers are on and the reference left zero
module power_stage_model (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       gate_driver_enable,
    input  wire logic [7:0] dac_code,
    input  wire logic [7:0] lag,
    output logic      [2:0] first_pulse
);
    logic [7:0] lag_cnt_q;

    // Pulses stop at once when the drivers are switched off
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lag_cnt_q   <= 8'h00;
            first_pulse <= 3'b000;
        end
        else if (!gate_driver_enable || dac_code == 8'h00)
        begin
            lag_cnt_q   <= 8'h00;
            first_pulse <= 3'b000;
        end
        else if (lag_cnt_q == lag)
            first_pulse <= 3'b111;
        else
            lag_cnt_q <= lag_cnt_q + 8'h01;
    end
endmodule : power_stage_model

//--- dv/rail_startup_config_sequencer_tb.sv
`timescale 1ns/1ps
module rail_startup_config_sequencer_tb;
    import rail_seq_pkg::*;

    typedef struct packed {
        logic       a_off;
        logic       b_off;
        logic       mon_off;
        logic       dual_s;
        logic [7:0] fs;
        logic [7:0] fs_exp;
    } row_t;

    logic        clk_sys, reset_n, supply_ok, enable_in;
    logic [3:0]  addr_strap, bus_addr;
    logic        dual_rail_second_sense_in, sense_a_at_supply;
    logic        sense_b_at_supply, system_power_monitor_in;
    logic [7:0]  freq_strap_shared, freq_strap_aux, paddr, lag;
    adc_codes_t  adc_in;
    logic [2:0]  first_pulse, modulator_ramp_en;
    logic        bus_addr_valid, psel, penable, pwrite;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, gate_driver_enable, bus_addr_ack;
    pwm_level_t  pwm_out [4];
    logic [7:0]  dac_code, freq_shared, freq_aux;
    logic        dual_edge_ramp_en, shared_osc_master;
    int          fails, checked, i, k, n;
    // Rails on/off, monitor, phase count and clamped frequency codes
    row_t rows [4] = '{
        '{1'b0, 1'b0, 1'b0, 1'b0, 8'h30, 8'h30},
        '{1'b1, 1'b0, 1'b1, 1'b0, 8'h05, 8'h14},
        '{1'b0, 1'b1, 1'b0, 1'b1, 8'hff, 8'h78},
        '{1'b1, 1'b1, 1'b1, 1'b1, 8'h14, 8'h14}};

    rail_startup_config_sequencer dut (.*);
    power_stage_model stage (.clk_sys(clk_sys), .reset_n(reset_n),
        .gate_driver_enable(gate_driver_enable), .dac_code(dac_code),
        .lag(lag), .first_pulse(first_pulse));

    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task end_sim;
        if (fails == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            fails++;
        end
    endtask : chk

    // A bound that runs out ends the run with a mismatch
    task tmo(input logic hit);
        if (hit)
        begin
            $display("ERROR wait expected done seen timeout");
            fails++;
            end_sim();
        end
    endtask : tmo

    // One APB transfer; request held until pready is seen high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk_sys);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        tmo(n == 20);
    endtask : apb

    // Strap set-up is only taken on a fresh rise of the supply
    task capture(input row_t r);
        @(posedge clk_sys);
        supply_ok                 <= 1'b0;
        sense_a_at_supply         <= r.a_off;
        sense_b_at_supply         <= r.b_off;
        system_power_monitor_in   <= r.mon_off;
        dual_rail_second_sense_in <= r.dual_s;
        freq_strap_shared         <= r.fs;
        freq_strap_aux            <= r.fs;
        addr_strap                <= {r.dual_s, r.a_off, r.b_off, r.mon_off};
        repeat (4) @(posedge clk_sys);
        supply_ok <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask : capture

    task ack_chk(input logic [3:0] a, input logic e);
        @(posedge clk_sys);
        bus_addr       <= a;
        bus_addr_valid <= 1'b1;
        @(negedge clk_sys);
        chk("bus_addr_ack", {31'h0, e}, {31'h0, bus_addr_ack});
    endtask : ack_chk

    initial
    begin
        fails = 0;
        checked = 0;
        reset_n = 1'b0;
        {supply_ok, enable_in, bus_addr_valid, psel, penable} = '0;
        {pwrite, dual_rail_second_sense_in, sense_a_at_supply} = '0;
        {sense_b_at_supply, system_power_monitor_in} = '0;
        {addr_strap, bus_addr, paddr, pwdata} = '0;
        freq_strap_shared = 8'h30;
        freq_strap_aux = 8'h30;
        lag = 8'd20;
        adc_in = '{8'h65, 8'hc8, 8'h40, 8'h50};
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl_reset", 32'h0000_0400, rd);
        // Table of strap cases, each captured on a supply rise
        for (i = 0; i < 4; i++)
        begin
            capture(rows[i]);
            ack_chk(4'h2, !rows[i].a_off);
            ack_chk(4'h3, !rows[i].b_off);
            ack_chk(4'hd, !rows[i].mon_off);
            chk("freq_shared", rows[i].fs_exp, freq_shared);
            chk("freq_aux", rows[i].fs_exp, freq_aux);
            chk("osc_master", !rows[i].dual_s, shared_osc_master);
            apb(1'b0, 8'h08, 32'h0);
            chk("strap", {24'h0, addr_strap, addr_strap}, rd);
            for (k = 0; k < 4; k++)
                chk("pwm_parked", PWM_MID, pwm_out[k]);
        end
        // straps frozen while supply stays up
        capture(rows[0]);
        @(posedge clk_sys);
        sense_a_at_supply       <= 1'b1;
        system_power_monitor_in <= 1'b1;
        ack_chk(4'h2, 1'b1);
        ack_chk(4'hd, 1'b1);
        // ramp supply below lockout holds the start
        @(posedge clk_sys);
        enable_in <= 1'b1;
        apb(1'b1, 8'h00, 32'h0003_0101);
        repeat (10) @(negedge clk_sys);
        chk("gate_low", 32'h0, gate_driver_enable);
        @(posedge clk_sys);
        adc_in.ramp_supply <= 8'h66;
        for (i = 0; i < 20 && gate_driver_enable !== 1'b1; i++)
            @(negedge clk_sys);
        tmo(i == 20);
        chk("dac_start", 32'h0, dac_code);
        chk("pwm_wait", PWM_MID, pwm_out[0]);
        for (i = 0; i < 100 && dac_code !== 8'h03; i++)
            @(negedge clk_sys);
        tmo(i == 100);
        chk("ramp_cycles", 32'd6, i);
        chk("dual_edge", 32'h1, dual_edge_ramp_en);
        chk("mod_ramps", 32'h6, modulator_ramp_en);
        repeat (10) @(negedge clk_sys);
        chk("dac_hold", 32'h3, dac_code);
        apb(1'b0, 8'h0c, 32'h0);
        chk("iccmax", 32'h64, rd);
        apb(1'b0, 8'h10, 32'h0);
        chk("temps", 32'h0000_5040, rd);
        for (i = 0; i < 100 && pwm_out[0] !== PWM_HIGH; i++)
            @(negedge clk_sys);
        tmo(i == 100);
        // losing the ramp supply while running drops the drivers
        @(posedge clk_sys);
        adc_in.ramp_supply <= 8'h65;
        repeat (3) @(negedge clk_sys);
        chk("gate_supply_lockout", 32'h0, gate_driver_enable);
        chk("pwm_supply_lockout", PWM_MID, pwm_out[0]);
        @(posedge clk_sys);
        adc_in.ramp_supply <= 8'h66;
        for (i = 0; i < 100 && pwm_out[0] !== PWM_HIGH; i++)
            @(negedge clk_sys);
        tmo(i == 100);
        apb(1'b1, 8'h00, 32'h0003_0100);
        repeat (3) @(negedge clk_sys);
        for (k = 0; k < 4; k++)
            chk("pwm_off", PWM_MID, pwm_out[k]);
        // Unmapped word answers with an error and zero data
        apb(1'b0, 8'h1c, 32'h0);
        chk("unmapped_err", 32'h1, err);
        chk("unmapped_data", 32'h0, rd);
        end_sim();
    end
endmodule : rail_startup_config_sequencer_tb
